// ==== pm_controller_model.sv ====
// Purpose: system power manager and supplies facing the sequencer
// Assumes: bench gives level commands
// Notes: regulation delay is an input, so one run covers prompt and slow
`timescale 1ns/1ps
`default_nettype none
module pm_controller_model
  import rail_seq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // bench commands
  input wire logic power_on_i,
  input wire logic sleep_i,
  input wire logic main_fail_i,
  input wire logic [9:0] reg_delay_i,
  // sequencer side
  input wire logic mem_on_i,
  input wire logic [1:0] mode_i,
  output logic ref_ok_o,
  output logic stby_uv_o,
  output logic main_uv_o,
  output logic suspend_o,
  output logic in_reg_o
);
  logic [9:0] reg_cnt_r;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_ok_o <= 1'h0;
      stby_uv_o <= 1'h1;
      main_uv_o <= 1'h1;
      suspend_o <= 1'h0;
      in_reg_o <= 1'h0;
      reg_cnt_r <= 10'h000;
    end else begin
      stby_uv_o <= !power_on_i;
      ref_ok_o <= !stby_uv_o;
      if (mode_i == MODE_S3 && sleep_i)
        main_uv_o <= 1'h1;
      else
        main_uv_o <= main_fail_i || !ref_ok_o;
      // suspend only drops once main is good again
      if (sleep_i)
        suspend_o <= 1'h1;
      else if (!main_uv_o)
        suspend_o <= 1'h0;
      reg_cnt_r <= mem_on_i ? reg_cnt_r + 10'(reg_cnt_r != reg_delay_i) : 10'h000;
      in_reg_o <= mem_on_i && reg_cnt_r == reg_delay_i;
    end
  end
endmodule
`default_nettype wire

// ==== rail_seq_cfg.svh ====
// Purpose: constants for the rail sequencer (offsets, fields, resets, timing)
// Assumes: 50 MHz reference clock
// Notes: times are kept in their own units and converted to cycles here
`ifndef RAIL_SEQ_CFG_SVH
`define RAIL_SEQ_CFG_SVH

// clock
`define CLK_MHZ 50
// soft-start: ramp time = 1.2 V * C / I, voltage kept in tenths
`define SS_RAMP_VX10 12
`define SS_I_MEM_UA 4
`define SS_I_HUB_UA 8
`define SS_CNT_W 24
// soft-start pin grounding interval between rails
`define SS_DISCHARGE_NS 2000
`define SS_DISCHARGE_CYC ((`SS_DISCHARGE_NS * `CLK_MHZ) / 1000)

// register byte offsets
`define REG_CTRL 8'h00
`define REG_SS_CAP 8'h04
`define REG_STATUS 8'h08

// control fields and reset values
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 1'h1
`define SS_CAP_RESET 16'h03E8

// status fields
`define ST_MODE_LSB 0
`define ST_STATE_LSB 4
`define ST_OC_BIT 8
`define ST_THERM_BIT 9
`define ST_PINS_LSB 10

`endif

// ==== rail_seq_pkg.sv ====
// Purpose: types shared by the rail sequencer modules
// Assumes: nothing beyond the cfg header
// Notes: codes count up from zero in listed order
package rail_seq_pkg;

  typedef enum logic [3:0] {
    ST_S5_OFF,
    ST_MEM_RAMP,
    ST_MEM_GND,
    ST_HUB_RAMP,
    ST_HUB_GND,
    ST_S0_ON,
    ST_S3_SLEEP,
    ST_OC_LATCH,
    ST_THERM_OFF
  } seq_state_t;

  typedef enum logic [1:0] {
    MODE_S5,
    MODE_S0,
    MODE_S3
  } acpi_mode_t;

endpackage

// ==== rail_sequencer.sv ====
// Purpose: ACPI S0/S3/S5 sequencer for memory, hub core and termination rails
// Assumes: pin inputs asynchronous; classic Wishbone register access
// Notes: one shared soft-start pin, thermal hysteresis, memory overcurrent latch (overcurrent acted on in S0 only)
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rail_seq_cfg.svh"
module rail_sequencer
  import rail_seq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // supply monitors, control and status pins (asynchronous)
  input wire logic reference_valid_i,
  input wire logic suspend_request_i,
  input wire logic main_supply_undervoltage_i,
  input wire logic standby_supply_undervoltage_i,
  input wire logic memory_rail_in_regulation_i,
  input wire logic memory_rail_overcurrent_i,
  input wire logic temp_above_shutdown_i,
  input wire logic temp_below_resume_i,
  // rail controls
  output logic memory_rail_en_o,
  output logic memory_rail_standby_o,
  output logic hub_core_rail_en_o,
  output logic termination_rail_en_o,
  // shared soft-start pin
  output logic ss_to_memory_o,
  output logic ss_to_hub_o,
  output logic ss_ground_o,
  // mode report
  output logic [1:0] acpi_mode_o
);

  localparam int N_PINS = 8;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [N_PINS-1:0] pin_raw;
  logic [N_PINS-1:0] pin_meta_r;
  logic [N_PINS-1:0] pin_sync_r;

  assign pin_raw = {temp_below_resume_i, temp_above_shutdown_i,
                    memory_rail_overcurrent_i, memory_rail_in_regulation_i,
                    standby_supply_undervoltage_i, main_supply_undervoltage_i,
                    suspend_request_i, reference_valid_i};

  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi = gi + 1) begin : g_sync
      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          pin_meta_r[gi] <= 1'b0;
          pin_sync_r[gi] <= 1'b0;
        end else begin
          pin_meta_r[gi] <= pin_raw[gi];
          pin_sync_r[gi] <= pin_meta_r[gi];
        end
      end
    end
  endgenerate

  wire ref_ok = pin_sync_r[0];
  wire susp = pin_sync_r[1];
  wire main_uv = pin_sync_r[2];
  wire stby_uv = pin_sync_r[3];
  wire mem_inreg = pin_sync_r[4];
  wire mem_oc = pin_sync_r[5];
  wire temp_hot = pin_sync_r[6];
  wire temp_cool = pin_sync_r[7];

  wire supplies_good = !main_uv && !stby_uv;
  wire any_uv = main_uv || stby_uv;
  // undervoltage only counts with suspend low
  wire uv_shutdown = any_uv && !susp;

  ////////////////////////////////////////////////////////////////////////////
  // registers and wishbone slave

  logic ctrl_enable_r;
  logic [15:0] ss_cap_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic [31:0] status_word;
  logic [31:0] rdat_nxt;
  logic oc_latched_r;
  logic over_temp_r;
  seq_state_t state_r;
  seq_state_t state_nxt;
  acpi_mode_t mode_nxt;

  // ack one cycle after the request, dropped the cycle after
  wire wb_req = wb_cyc_i && wb_stb_i && !ack_r;
  wire wb_wr = wb_req && wb_we_i;
  wire hit_ctrl = (wb_adr_i == `REG_CTRL);
  wire hit_cap = (wb_adr_i == `REG_SS_CAP);
  wire hit_status = (wb_adr_i == `REG_STATUS);

  assign status_word = {16'h0000, pin_sync_r[5:0], over_temp_r, oc_latched_r,
                        state_r, 2'h0, mode_nxt};

  // unmapped addresses read as zero and still get an ack
  assign rdat_nxt = hit_ctrl ? {31'h0, ctrl_enable_r} :
                    hit_cap ? {16'h0000, ss_cap_r} :
                    hit_status ? status_word : 32'h0000_0000;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req;
      rdat_r <= wb_req ? rdat_nxt : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_enable_r <= `CTRL_RESET;
      ss_cap_r <= `SS_CAP_RESET;
    end else if (wb_wr) begin
      if (hit_ctrl && wb_sel_i[0])
        ctrl_enable_r <= wb_dat_i[`CTRL_ENABLE_BIT];
      if (hit_cap && wb_sel_i[0])
        ss_cap_r[7:0] <= wb_dat_i[7:0];
      if (hit_cap && wb_sel_i[1])
        ss_cap_r[15:8] <= wb_dat_i[15:8];
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  ////////////////////////////////////////////////////////////////////////////
  // thermal hysteresis and overcurrent latch flags

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      over_temp_r <= 1'b0;
    end else if (temp_hot) begin
      // trip at 150C wins over the resume level
      over_temp_r <= 1'b1;
    end else if (temp_cool) begin
      over_temp_r <= 1'b0;
    end
  end

  // remembers that a monitored supply dropped while latched off
  logic uv_seen_r;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oc_latched_r <= 1'b0;
      uv_seen_r <= 1'b0;
    end else begin
      oc_latched_r <= (state_nxt == ST_OC_LATCH);
      uv_seen_r <= (state_r == ST_OC_LATCH) && (uv_seen_r || any_uv);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // soft-start timer and pin grounding interval

  ss_timer_if ss_bus ();
  logic [15:0] dis_cnt_r;

  ss_timer u_ss_timer (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .ss(ss_bus.timer)
  );

  // slow ramp for memory, fast ramp for hub core
  assign ss_bus.cap_pf = ss_cap_r;
  assign ss_bus.fast = (state_nxt == ST_HUB_RAMP);
  assign ss_bus.start = (state_nxt != state_r) &&
                        ((state_nxt == ST_MEM_RAMP) || (state_nxt == ST_HUB_RAMP));

  wire dis_done = (dis_cnt_r >= 16'(`SS_DISCHARGE_CYC - 1));

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dis_cnt_r <= 16'h0000;
    end else if (state_nxt != state_r) begin
      dis_cnt_r <= 16'h0000;
    end else if (!dis_done) begin
      dis_cnt_r <= dis_cnt_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode state machine

  always_comb begin
    state_nxt = state_r;
    if (over_temp_r) begin
      state_nxt = ST_THERM_OFF;
    end else begin
      case (state_r)
        ST_S5_OFF: begin
          // leave S5 only with reference, supplies good, suspend low
          if (ref_ok && ctrl_enable_r && supplies_good && !susp)
            state_nxt = ST_MEM_RAMP;
        end
        ST_MEM_RAMP: begin
          if (uv_shutdown)
            state_nxt = ST_S5_OFF;
          // memory ramp done, release and ground the pin
          else if (ss_bus.done && mem_inreg)
            state_nxt = ST_MEM_GND;
        end
        ST_MEM_GND: begin
          if (uv_shutdown)
            state_nxt = ST_S5_OFF;
          else if (dis_done)
            state_nxt = ST_HUB_RAMP;
        end
        ST_HUB_RAMP: begin
          if (uv_shutdown)
            state_nxt = ST_S5_OFF;
          // hub ramp done, ground the pin
          else if (ss_bus.done)
            state_nxt = ST_HUB_GND;
        end
        ST_HUB_GND: begin
          if (uv_shutdown)
            state_nxt = ST_S5_OFF;
          else if (dis_done)
            state_nxt = ST_S0_ON;
        end
        ST_S0_ON: begin
          if (mem_oc)
            state_nxt = ST_OC_LATCH;
          else if (susp)
            state_nxt = ST_S3_SLEEP;
          else if (any_uv)
            state_nxt = ST_S5_OFF;
        end
        ST_S3_SLEEP: begin
          // supply loss ignored here; no exit to S5
          // main back and suspend low re-ramps the hub core
          if (!susp && !main_uv)
            state_nxt = ST_HUB_RAMP;
        end
        ST_OC_LATCH: begin
          // restart only once a supply has dropped and returned
          if (uv_seen_r && supplies_good)
            state_nxt = ST_S5_OFF;
        end
        ST_THERM_OFF: begin
          state_nxt = ST_S5_OFF;
        end
        default: begin
          state_nxt = ST_S5_OFF;
        end
      endcase
    end
  end

  // no hub core fault input exists, so nothing can latch that rail
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // power-up lands in S5; reset stands in for the standby enable
      state_r <= ST_S5_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output decode, registered from the next state

  // {mem_en, mem_stby, hub_en, term_en, ss_mem, ss_hub, ss_gnd}
  function automatic logic [6:0] rail_word(input seq_state_t st);
    case (st)
      ST_MEM_RAMP: rail_word = 7'h44;
      ST_MEM_GND: rail_word = 7'h41;
      ST_HUB_RAMP: rail_word = 7'h5A;
      ST_HUB_GND: rail_word = 7'h59;
      ST_S0_ON: rail_word = 7'h59;
      ST_S3_SLEEP: rail_word = 7'h61;
      default: rail_word = 7'h01;
    endcase
  endfunction

  // S0 only after hub grounding; ramps hold the mode, so S3 shows S5 only on a thermal trip or a fault in the hub re-ramp
  assign mode_nxt = (state_nxt == ST_S0_ON) ? MODE_S0 :
                    (state_nxt == ST_S3_SLEEP) ? MODE_S3 :
                    (state_nxt inside {ST_S5_OFF, ST_OC_LATCH, ST_THERM_OFF}) ? MODE_S5 :
                    acpi_mode_t'(acpi_mode_o);

  wire [6:0] rail_nxt = rail_word(state_nxt);

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {memory_rail_en_o, memory_rail_standby_o, hub_core_rail_en_o,
       termination_rail_en_o, ss_to_memory_o, ss_to_hub_o, ss_ground_o} <= 7'h01;
      acpi_mode_o <= MODE_S5;
    end else begin
      // termination rises with the hub ramp; both drop in S3
      {memory_rail_en_o, memory_rail_standby_o, hub_core_rail_en_o,
       termination_rail_en_o, ss_to_memory_o, ss_to_hub_o, ss_ground_o} <= rail_nxt;
      acpi_mode_o <= mode_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== rail_sequencer_checker.sv ====
// Purpose: port-level checks of the rail sequencer
// Assumes: bound to rail_sequencer, one clock domain
// Notes: pin inputs pass two sync flops, hence the guard depths
`timescale 1ns/1ps
`default_nettype none
module rail_sequencer_checker
  import rail_seq_pkg::*;
(
  // clock, reset and watched pin
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic temp_above_shutdown_i,
  // rail controls and mode
  input wire logic memory_rail_en_o,
  input wire logic memory_rail_standby_o,
  input wire logic hub_core_rail_en_o,
  input wire logic termination_rail_en_o,
  input wire logic ss_to_memory_o,
  input wire logic ss_to_hub_o,
  input wire logic ss_ground_o,
  input wire logic [1:0] acpi_mode_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // standby counts as supplied
  wire mem_on = memory_rail_en_o | memory_rail_standby_o;
  ////////////////////////////////////////////////////////////////////
  mem_first_a: assert property ($rose(mem_on) |-> ss_to_memory_o && !hub_core_rail_en_o)
    else $error("memory rail did not start alone on the pin");
  pin_excl_a: assert property (!(ss_ground_o && (ss_to_memory_o || ss_to_hub_o)))
    else $error("soft-start pin grounded while given to a rail");
  hub_after_gnd_a: assert property ($rose(ss_to_hub_o) |-> $past(ss_ground_o))
    else $error("hub took the pin without grounding first");
  hub_term_a: assert property (hub_core_rail_en_o == termination_rail_en_o)
    else $error("hub and termination rails differ");
  hub_needs_mem_a: assert property (hub_core_rail_en_o |-> mem_on)
    else $error("hub rail on without memory rail");
  s0_rails_a: assert property (acpi_mode_o == MODE_S0 |-> mem_on && hub_core_rail_en_o)
    else $error("S0 reported with a rail off");
  s3_rails_a: assert property (acpi_mode_o == MODE_S3 |-> mem_on && (memory_rail_standby_o ?
    !termination_rail_en_o && !hub_core_rail_en_o : hub_core_rail_en_o))
    else $error("S3 rails wrong");
  thermal_off_a: assert property (temp_above_shutdown_i [*6] |-> !mem_on && !hub_core_rail_en_o)
    else $error("rails still on while hot");
  s3_no_s5_a: assert property (acpi_mode_o == MODE_S3 && !temp_above_shutdown_i
    && !$past(temp_above_shutdown_i) && !$past(temp_above_shutdown_i, 2)
    |=> acpi_mode_o != MODE_S5) else $error("direct move from S3 to S5");
  s5_no_s3_a: assert property (acpi_mode_o == MODE_S5 |=> acpi_mode_o != MODE_S3)
    else $error("direct move from S5 to S3");
endmodule
bind rail_sequencer rail_sequencer_checker chk_u (.ref_clk_i, .rstn_i, .temp_above_shutdown_i,
  .memory_rail_en_o, .memory_rail_standby_o, .hub_core_rail_en_o, .termination_rail_en_o,
  .ss_to_memory_o, .ss_to_hub_o, .ss_ground_o, .acpi_mode_o);
`default_nettype wire

// ==== ss_timer.sv ====
// Purpose: soft-start ramp timer, length set by the soft-start capacitance
// Assumes: cap_pf stable while a ramp runs
// Notes: ramp cycles = 1.2 * C / I * f, never below one cycle
`timescale 1ns/1ps
`default_nettype none
`include "rail_seq_cfg.svh"
module ss_timer
  import rail_seq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // sequencer side
  ss_timer_if.timer ss
);

  logic [`SS_CNT_W-1:0] cnt_r;
  logic [`SS_CNT_W-1:0] target_r;
  logic run_r;
  logic [31:0] prod;
  logic [31:0] div_mem;
  logic [31:0] div_hub;
  logic [`SS_CNT_W-1:0] target_nxt;
  logic [`SS_CNT_W-1:0] ramp_sel;

  assign prod = 32'(ss.cap_pf) * `SS_RAMP_VX10 * `CLK_MHZ;
  assign div_mem = prod / (10 * `SS_I_MEM_UA);
  assign div_hub = prod / (10 * `SS_I_HUB_UA);
  // a zero capacitance still gives one cycle of ramp
  assign ramp_sel = ss.fast ? div_hub[`SS_CNT_W-1:0] : div_mem[`SS_CNT_W-1:0];
  assign target_nxt = (ramp_sel == '0) ? `SS_CNT_W'(1) : ramp_sel;
  assign ss.done = run_r && (cnt_r >= target_r);

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= '0;
      target_r <= '0;
      run_r <= 1'b0;
    end else if (ss.start) begin
      cnt_r <= '0;
      target_r <= target_nxt;
      run_r <= 1'b1;
    end else if (run_r && !ss.done) begin
      cnt_r <= cnt_r + `SS_CNT_W'(1);
    end
  end

endmodule
`default_nettype wire

// ==== ss_timer_if.sv ====
// Purpose: link between the sequencer and its soft-start timer
// Assumes: single clock domain
// Notes: start is a one-cycle pulse, done is a level
`timescale 1ns/1ps
`default_nettype none
interface ss_timer_if;
  logic start;
  logic fast;
  logic [15:0] cap_pf;
  logic done;

  modport seq (output start, output fast, output cap_pf, input done);
  modport timer (input start, input fast, input cap_pf, output done);
endinterface
`default_nettype wire

// ==== tb_acpi_rail_sequencer.sv ====
// Purpose: self-checking bench for the rail sequencer
// Assumes: 10 pF soft-start, giving 150 and 75 cycle ramps
// Notes: checks read pre-edge values right after each rising edge
`timescale 1ns/1ps
`default_nettype none
`include "rail_seq_cfg.svh"
module tb_acpi_rail_sequencer
  import rail_seq_pkg::*;
;
  logic ref_clk_i, rstn_i, cyc, stb, we, oc, hot, cool, pwr, slp, mfail;
  logic [7:0] adr;
  logic [31:0] wdat, rd;
  logic [9:0] dly;
  logic [1:0] ht;
  wire logic [31:0] rdat;
  wire logic ack, mem_en, mem_sb, hub_en, term_en, ss_m, ss_h, ss_g;
  wire logic ref_ok, stby_uv, main_uv, susp, in_reg;
  wire logic [1:0] mode;
  int fail_count = 0;
  int tests_run = 0;
  int n, g;
  rail_sequencer dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .reference_valid_i(ref_ok), .suspend_request_i(susp),
    .main_supply_undervoltage_i(main_uv), .standby_supply_undervoltage_i(stby_uv),
    .memory_rail_in_regulation_i(in_reg), .memory_rail_overcurrent_i(oc),
    .temp_above_shutdown_i(hot), .temp_below_resume_i(cool), .memory_rail_en_o(mem_en),
    .memory_rail_standby_o(mem_sb), .hub_core_rail_en_o(hub_en),
    .termination_rail_en_o(term_en), .ss_to_memory_o(ss_m), .ss_to_hub_o(ss_h),
    .ss_ground_o(ss_g), .acpi_mode_o(mode));
  pm_controller_model pm_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .power_on_i(pwr),
    .sleep_i(slp), .main_fail_i(mfail), .reg_delay_i(dly), .mem_on_i(mem_en | mem_sb),
    .mode_i(mode), .ref_ok_o(ref_ok), .stby_uv_o(stby_uv), .main_uv_o(main_uv),
    .suspend_o(susp), .in_reg_o(in_reg));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (ack !== 1'h1 && k < 20);
    rd = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    chk(k < 20, 1'h1);
  endtask
  // cycles before the pin is handed over, then cycles it is held
  task automatic span(input bit hub, output int lo, output int hi);
    lo = 0;
    hi = 0;
    while ((hub ? ss_h : ss_m) !== 1'h1 && lo < 2000) begin
      @(posedge ref_clk_i);
      lo++;
    end
    ht = {hub_en, term_en};
    while ((hub ? ss_h : ss_m) === 1'h1 && hi < 2000) begin
      @(posedge ref_clk_i);
      hi++;
    end
  endtask
  task automatic wait_mode(input logic [1:0] m);
    int k;
    k = 0;
    while (mode !== m && k < 3000) begin
      @(posedge ref_clk_i);
      k++;
    end
    chk(mode, m);
  endtask
  task automatic bring_up(input int lo_m, input int hi_m);
    span(1'b0, g, n);
    chk(n >= lo_m && n <= hi_m, 1'h1);
    span(1'b1, g, n);
    chk(g >= 100 && g <= 104, 1'h1);
    chk(n >= 75 && n <= 80, 1'h1);
    chk(ht, 2'h3);
    chk({hub_en, term_en}, 2'h3);
    wait_mode(MODE_S0);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'h0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    test_done;
  end
  initial begin
    {rstn_i, cyc, stb, we, oc, hot, pwr, slp, mfail} = 9'h000;
    cool = 1'h1;
    adr = 8'h00;
    wdat = 32'h0;
    dly = 10'h028;
    repeat (6) @(posedge ref_clk_i);
    rstn_i <= 1'h1;
    chk({mem_en, hub_en, term_en, ss_g, mode}, {4'h1, MODE_S5});
    wb(1'h0, `REG_CTRL, 32'h0);
    chk(rd, 32'h1);
    wb(1'h0, `REG_SS_CAP, 32'h0);
    chk(rd, 32'h3E8);
    wb(1'h1, `REG_SS_CAP, 32'hA);
    wb(1'h0, `REG_SS_CAP, 32'h0);
    chk(rd, 32'hA);
    wb(1'h1, 8'hFC, 32'hFFFFFFFF);
    wb(1'h0, 8'hFC, 32'h0);
    chk(rd, 32'h0);
    repeat (20) @(posedge ref_clk_i);
    chk(mem_en, 1'h0);
    wb(1'h1, `REG_CTRL, 32'h0);
    pwr <= 1'h1;
    repeat (20) @(posedge ref_clk_i);
    chk({mem_en, ss_m, mode}, {2'h0, MODE_S5});
    wb(1'h1, `REG_CTRL, 32'h1);
    bring_up(150, 156);
    wb(1'h0, `REG_STATUS, 32'h0);
    chk({rd[7:4], rd[1:0]}, {4'h5, MODE_S0});
    slp <= 1'h1;
    wait_mode(MODE_S3);
    chk({mem_en | mem_sb, hub_en, term_en}, 3'h4);
    repeat (60) @(posedge ref_clk_i);
    chk({main_uv, mode}, {1'h1, MODE_S3});
    slp <= 1'h0;
    span(1'b1, g, n);
    chk(n >= 75 && n <= 80, 1'h1);
    chk(ht, 2'h3);
    wait_mode(MODE_S0);
    mfail <= 1'h1;
    wait_mode(MODE_S5);
    chk({mem_en, hub_en, term_en}, 3'h0);
    dly <= 10'h12C;
    mfail <= 1'h0;
    bring_up(300, 320);
    dly <= 10'h028;
    oc <= 1'h1;
    repeat (8) @(posedge ref_clk_i);
    oc <= 1'h0;
    repeat (60) @(posedge ref_clk_i);
    chk({mem_en, mem_sb, hub_en, term_en}, 4'h0);
    wb(1'h0, `REG_STATUS, 32'h0);
    chk({rd[9:8], rd[7:4]}, {2'h1, 4'h7});
    mfail <= 1'h1;
    repeat (10) @(posedge ref_clk_i);
    mfail <= 1'h0;
    bring_up(150, 156);
    hot <= 1'h1;
    cool <= 1'h0;
    repeat (6) @(posedge ref_clk_i);
    chk({mem_en, mem_sb, hub_en, term_en}, 4'h0);
    hot <= 1'h0;
    repeat (60) @(posedge ref_clk_i);
    chk({mem_en, mem_sb, hub_en, term_en}, 4'h0);
    wb(1'h0, `REG_STATUS, 32'h0);
    chk({rd[9:8], rd[7:4]}, {2'h2, 4'h8});
    cool <= 1'h1;
    bring_up(150, 156);
    test_done;
  end
endmodule
`default_nettype wire
